// ==== core/wsr_top.sv ====
// Summary of operation
// - A software reset is produced whether or not supervision was running.
// - Supervision is left disabled once a software reset has completed.
// - A software reset acts exactly like a supervision overflow reset.
// - The first key followed by a non-key value triggers the reset.
// - One key register write alone never causes a software reset.
// - A clearing key pair slipped between the two writes cancels the reset.
// - Fetching resumes three machine cycles after the triggering write.
// - One machine cycle of normal execution follows the triggering write.
// - The reset returns all state to reset values and leaves RAM untouched.
// - The first key then the second key clears or enables supervision.
// - Overflow of running supervision resets and clears the toggle bit.
`timescale 1ns/1ps
module wsr_top
#(
   parameter int COUNT_WIDTH = wsr_pkg::SUPERVISION_WIDTH,
   parameter int TOGGLE_BITS = wsr_pkg::TOGGLE_SPAN
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic machine_cycle,
   input wire logic key_write,
   input wire logic [wsr_pkg::KEY_WIDTH-1:0] watchdog_key_register,
   output logic reset_request,
   output logic supervision_running,
   output logic timer_verify_toggle
);
   import wsr_pkg::*;

   wsr_cnt_if cnt_bus ();

   wsr_key_type key_state;
   wsr_seq_type seq_state;
   logic [MC_COUNT_WIDTH-1:0] mc_count;
   logic clear_pulse;
   logic write_taken;
   logic bad_second;
   logic good_second;
   logic start_reset;

   function automatic logic is_key(input logic [KEY_WIDTH-1:0] value);
      return (value == KEY_FIRST) || (value == KEY_SECOND);
   endfunction

   // True when the machine cycle ending now completes the given step.
   function automatic logic mc_reaches(
      input logic [MC_COUNT_WIDTH-1:0] count,
      input logic [MC_COUNT_WIDTH-1:0] target);
      return MC_COUNT_WIDTH'(count + MC_ONE) == target;
   endfunction

   // Writes are ignored while the core is held in reset.
   assign write_taken = clk_en && key_write && (seq_state == SEQ_RUN);
   assign good_second = write_taken && (key_state == KEY_ARMED)
      && (watchdog_key_register == KEY_SECOND);
   assign bad_second = write_taken && (key_state == KEY_ARMED)
      && !is_key(watchdog_key_register);
   // Overflow enters the same sequence so both resets are identical.
   assign start_reset = (seq_state == SEQ_RUN)
      && (bad_second || (clk_en && cnt_bus.overflow));

   assign cnt_bus.run = supervision_running;
   assign cnt_bus.clear = clear_pulse;
   assign cnt_bus.tick = machine_cycle;
   assign timer_verify_toggle = cnt_bus.verify_toggle;

   wsr_counter
   #(
      .WIDTH(COUNT_WIDTH),
      .TOGGLE_BITS(TOGGLE_BITS)
   )
   u_counter
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .port(cnt_bus.cnt)
   );

   // A clearing pair from an interrupt handler consumes the armed state,
   // so the interrupted request's non-key write then finds the block idle.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         key_state <= KEY_IDLE;
      end
      else if (clk_en)
      begin
         if (seq_state != SEQ_RUN)
         begin
            key_state <= KEY_IDLE;
         end
         else if (write_taken)
         begin
            unique case (key_state)
               KEY_IDLE:
               begin
                  if (watchdog_key_register == KEY_FIRST)
                  begin
                     key_state <= KEY_ARMED;
                  end
               end
               KEY_ARMED:
               begin
                  key_state <= KEY_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         clear_pulse <= 1'b0;
      end
      else if (clk_en)
      begin
         clear_pulse <= good_second || (seq_state == SEQ_HOLD);
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         supervision_running <= 1'b0;
      end
      else if (clk_en)
      begin
         if (seq_state == SEQ_HOLD)
         begin
            supervision_running <= 1'b0;
         end
         else if (good_second)
         begin
            supervision_running <= 1'b1;
         end
      end
   end

   // The write's own machine cycle ends at the first tick, the normal
   // cycle at the second, and the reset cycle at the third.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         seq_state <= SEQ_RUN;
         mc_count <= MC_ZERO;
      end
      else if (clk_en)
      begin
         unique case (seq_state)
            SEQ_RUN:
            begin
               if (start_reset)
               begin
                  seq_state <= SEQ_GRACE;
                  mc_count <= machine_cycle ? MC_ONE : MC_ZERO;
               end
            end
            SEQ_GRACE:
            begin
               if (machine_cycle)
               begin
                  mc_count <= mc_count + MC_ONE;
                  if (mc_reaches(mc_count, MC_ASSERT_AT))
                  begin
                     seq_state <= SEQ_HOLD;
                  end
               end
            end
            SEQ_HOLD:
            begin
               if (machine_cycle)
               begin
                  mc_count <= mc_count + MC_ONE;
                  if (mc_reaches(mc_count, MC_RELEASE_AT))
                  begin
                     seq_state <= SEQ_RUN;
                     mc_count <= MC_ZERO;
                  end
               end
            end
            default:
            begin
               seq_state <= SEQ_RUN;
               mc_count <= MC_ZERO;
            end
         endcase
      end
   end

   // Only registers see this request; RAM keeps its contents as a marker.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         reset_request <= 1'b0;
      end
      else if (clk_en)
      begin
         reset_request <= (seq_state == SEQ_GRACE && machine_cycle
            && mc_reaches(mc_count, MC_ASSERT_AT))
            || (seq_state == SEQ_HOLD && !(machine_cycle
            && mc_reaches(mc_count, MC_RELEASE_AT)));
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence s_armed_write;
      clk_en && key_write && seq_state == SEQ_RUN && key_state == KEY_ARMED;
   endsequence

   sequence s_idle_write;
      clk_en && key_write && seq_state == SEQ_RUN && key_state == KEY_IDLE;
   endsequence

   a_single_write_safe: assert property (
      (s_idle_write ##0 !cnt_bus.overflow) |=> seq_state == SEQ_RUN)
      else $error("Single key write started a reset.");

   a_bad_second_fires: assert property (
      (s_armed_write ##0 !is_key(watchdog_key_register))
      |=> seq_state == SEQ_GRACE)
      else $error("Non-key second write did not trigger.");

   a_good_pair_enables: assert property (
      (s_armed_write ##0 watchdog_key_register == KEY_SECOND)
      |=> supervision_running && clear_pulse && seq_state == SEQ_RUN)
      else $error("Key pair did not enable and clear.");

   a_next_write_closes: assert property (
      s_armed_write |=> key_state == KEY_IDLE)
      else $error("Sequence stayed armed after second write.");

   a_fire_when_stopped: assert property (
      (s_armed_write ##0 !supervision_running
      ##0 !is_key(watchdog_key_register)) |=> seq_state == SEQ_GRACE)
      else $error("Reset missing while supervision stopped.");

   a_grace_no_reset: assert property (
      (seq_state == SEQ_RUN && start_reset && clk_en && !machine_cycle)
      |=> !reset_request [*2])
      else $error("Reset asserted inside the normal cycle.");

   a_assert_at_count: assert property (
      $rose(reset_request) |-> $past(mc_count) + MC_ONE == MC_ASSERT_AT)
      else $error("Reset asserted at the wrong machine cycle.");

   a_release_at_count: assert property (
      $fell(reset_request) |-> $past(seq_state) == SEQ_HOLD
      && $past(mc_count) + MC_ONE == MC_RELEASE_AT && seq_state == SEQ_RUN)
      else $error("Reset released at the wrong machine cycle.");

   a_disabled_after: assert property (
      $fell(reset_request) |-> !supervision_running)
      else $error("Supervision still running after reset.");

   a_overflow_same: assert property (
      (seq_state == SEQ_RUN && clk_en && cnt_bus.overflow)
      |=> seq_state == SEQ_GRACE)
      else $error("Overflow did not take the reset path.");

endmodule

// ==== inc/wsr_pkg.sv ====
package wsr_pkg;

   localparam int KEY_WIDTH = 8;
   localparam logic [KEY_WIDTH-1:0] KEY_FIRST = 8'hA5;
   localparam logic [KEY_WIDTH-1:0] KEY_SECOND = 8'h5A;

   // MC_NORMAL_AFTER counts from the end of the triggering write's cycle, MC_FETCH_AFTER from its start.
   localparam int MC_NORMAL_AFTER = 1;
   localparam int MC_FETCH_AFTER = 3;
   localparam int MC_COUNT_WIDTH = 2;
   localparam logic [MC_COUNT_WIDTH-1:0] MC_ASSERT_AT =
      MC_COUNT_WIDTH'(MC_NORMAL_AFTER + 1);
   localparam logic [MC_COUNT_WIDTH-1:0] MC_RELEASE_AT =
      MC_COUNT_WIDTH'(MC_FETCH_AFTER);
   localparam logic [MC_COUNT_WIDTH-1:0] MC_ZERO = 2'h0;
   localparam logic [MC_COUNT_WIDTH-1:0] MC_ONE = 2'h1;

   localparam int SUPERVISION_WIDTH = 16;
   localparam int TOGGLE_SPAN = 13;

   typedef enum logic [0:0]
   {
      KEY_IDLE,
      KEY_ARMED
   } wsr_key_type;

   typedef enum logic [1:0]
   {
      SEQ_RUN,
      SEQ_GRACE,
      SEQ_HOLD
   } wsr_seq_type;

endpackage

// ==== inc/wsr_cnt_if.sv ====
`timescale 1ns/1ps
interface wsr_cnt_if;
   logic run;
   logic clear;
   logic tick;
   logic overflow;
   logic verify_toggle;

   modport ctrl
   (
      output run,
      output clear,
      output tick,
      input overflow,
      input verify_toggle
   );

   modport cnt
   (
      input run,
      input clear,
      input tick,
      output overflow,
      output verify_toggle
   );
endinterface

// ==== core/wsr_counter.sv ====
`timescale 1ns/1ps
module wsr_counter
#(
   parameter int WIDTH = wsr_pkg::SUPERVISION_WIDTH,
   parameter int TOGGLE_BITS = wsr_pkg::TOGGLE_SPAN
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   wsr_cnt_if.cnt port
);
   import wsr_pkg::*;

   logic [WIDTH-1:0] count;
   logic overflow;
   logic verify_toggle;
   logic wrap;
   logic half_wrap;

   assign wrap = port.run && port.tick && (&count);
   assign half_wrap = port.run && port.tick && (&count[TOGGLE_BITS-1:0]);
   assign port.overflow = overflow;
   assign port.verify_toggle = verify_toggle;

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         count <= '0;
      end
      else if (clk_en)
      begin
         if (port.clear || !port.run)
         begin
            count <= '0;
         end
         else if (port.tick)
         begin
            count <= count + WIDTH'(1);
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         overflow <= 1'b0;
      end
      else if (clk_en)
      begin
         overflow <= wrap && !port.clear;
      end
   end

   // The toggle restarts from zero on a clear and on an overflow.
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         verify_toggle <= 1'b0;
      end
      else if (clk_en)
      begin
         if (port.clear || wrap || !port.run)
         begin
            verify_toggle <= 1'b0;
         end
         else if (half_wrap)
         begin
            verify_toggle <= !verify_toggle;
         end
      end
   end

   a_toggle_overflow_clear: assert property (
      @(posedge sys_clk) disable iff (rst)
      (clk_en && wrap && !port.clear) |=> !verify_toggle && overflow)
      else $error("Toggle not cleared on overflow.");

endmodule

// ==== tb/test_wsr_top.sv ====
`timescale 1ns/1ps
module test_wsr_top;
   import wsr_pkg::*;
   // Short counts keep the overflow walk within a few dozen machine cycles.
   localparam int CW = 4;
   localparam int TB = 2;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic machine_cycle = 1'b0;
   logic key_write = 1'b0;
   logic [KEY_WIDTH-1:0] key_data = 8'h00;
   logic reset_request;
   logic supervision_running;
   logic timer_verify_toggle;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;

   wsr_top #(.COUNT_WIDTH(CW), .TOGGLE_BITS(TB)) i_wsr_top
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .machine_cycle(machine_cycle),
      .key_write(key_write),
      .watchdog_key_register(key_data),
      .reset_request(reset_request),
      .supervision_running(supervision_running),
      .timer_verify_toggle(timer_verify_toggle)
   );

   initial
   begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic results();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // A hung walk would otherwise run forever, so the cycle count is capped.
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         miscompares = miscompares + 1;
         results();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         miscompares++;
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // The strobe stays high across the whole burst, so writes are back to back.
   task automatic write_seq(input logic [31:0] vals, input int n);
      key_write = 1'b1;
      for (int i = 0; i < n; i++)
      begin
         key_data = vals[31-8*i -: 8];
         step(1);
      end
      key_write = 1'b0;
      step(1);
   endtask

   task automatic tick(input int n);
      repeat (n)
      begin
         machine_cycle = 1'b1;
         step(1);
         machine_cycle = 1'b0;
         step(1);
      end
   endtask

   task automatic t_single();
      write_seq({8'h11, 24'h0}, 1);
      tick(3);
      write_seq({8'h5A, 24'h0}, 1);
      tick(3);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h00);
      clk_en = 1'b0;
      write_seq({8'hA5, 8'h11, 16'h0}, 2);
      clk_en = 1'b1;
      tick(4);
      check(reset_request, 8'h00);
   endtask

   task automatic t_enable();
      write_seq({8'hA5, 8'h5A, 16'h0}, 2);
      check(supervision_running, 8'h01);
      write_seq({8'hA5, 8'hA5, 8'h11, 8'h0}, 3);
      tick(3);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h01);
   endtask

   task automatic t_cancel();
      write_seq({8'hA5, 8'hA5, 8'h5A, 8'h11}, 4);
      tick(4);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h01);
   endtask

   task automatic t_soft(input logic [7:0] key);
      write_seq({8'hA5, key, 16'h0}, 2);
      tick(1);
      check(reset_request, 8'h00);
      tick(1);
      check(reset_request, 8'h01);
      step(1);
      check(supervision_running, 8'h00);
      // An enabling pair inside the reset walk must not be taken.
      write_seq({8'hA5, 8'h5A, 16'h0}, 2);
      check(reset_request, 8'h01);
      tick(1);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h00);
      check(timer_verify_toggle, 8'h00);
   endtask

   task automatic t_overflow();
      logic seen_toggle;
      int n;
      seen_toggle = 1'b0;
      n = 0;
      write_seq({8'hA5, 8'h5A, 16'h0}, 2);
      // A clear part way keeps the counter short of its wrap.
      tick(12);
      write_seq({8'hA5, 8'h5A, 16'h0}, 2);
      tick(12);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h01);
      while (reset_request !== 1'b1 && n < 64)
      begin
         tick(1);
         n++;
         if (timer_verify_toggle === 1'b1)
            seen_toggle = 1'b1;
      end
      check(seen_toggle, 8'h01);
      check(reset_request, 8'h01);
      tick(1);
      check(reset_request, 8'h00);
      check(timer_verify_toggle, 8'h00);
      check(supervision_running, 8'h00);
   endtask

   task automatic t_mid_reset();
      write_seq({8'hA5, 8'h5A, 8'hA5, 8'h11}, 4);
      check(supervision_running, 8'h01);
      tick(2);
      check(reset_request, 8'h01);
      rst = 1'b1;
      step(2);
      check(reset_request, 8'h00);
      check(supervision_running, 8'h00);
      rst = 1'b0;
      // A sequence surviving the reset would raise the request here.
      step(1);
      check(reset_request, 8'h00);
      tick(3);
      check(reset_request, 8'h00);
   endtask

   initial
   begin
      step(5);
      rst = 1'b0;
      t_single();
      t_enable();
      t_cancel();
      t_soft(8'h11);
      t_soft(8'h00);
      write_seq({8'hA5, 8'h5A, 16'h0}, 2);
      t_soft(8'hFF);
      t_overflow();
      t_mid_reset();
      t_soft(8'h11);
      results();
   end
endmodule
